// >>> src/mxb_pins.sv
// mxb_pins: machine cycle sequencer for the external bus and port pins.
// Assumes the core issues one request per machine cycle on clk and
// reads internal program memory itself for internal fetches.
`timescale 1ns/1ps
module mxb_pins
   import mxb_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   // Core request side
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [2:0]  req_kind,
   input  wire logic [11:0] req_addr,
   input  wire logic [7:0]  req_wdata,
   input  wire logic        req_last,
   output logic             rd_valid,
   input  wire logic        rd_ready,
   output logic [7:0]       rd_data,
   input  wire logic        p1_wr,
   input  wire logic [7:0]  p1_wdata,
   input  wire logic        p2_wr,
   input  wire logic [7:0]  p2_wdata,
   input  wire logic        clock_out_enable,
   input  wire logic        event_count_start,
   output logic             test_a_level,
   output logic             test_b_level,
   output logic             irq_level,
   output logic             irq_request,
   output logic             count_event,
   output logic             core_reset_n,
   output logic             halted,
   // Shared bus and strobes
   input  wire logic [7:0]  bus_in,
   output logic [7:0]       bus_out,
   output logic             bus_oe,
   output logic             addr_strobe,
   output logic             fetch_strobe_n,
   output logic             read_strobe_n,
   output logic             write_strobe_n,
   output logic             exp_strobe_n,
   // Port pins
   input  wire logic [7:0]  first_port_lines_in,
   output logic [7:0]       first_port_lines_out,
   output logic [7:0]       first_port_lines_oe,
   output logic [7:0]       first_port_lines_rdata,
   input  wire logic [7:0]  second_port_lines_in,
   output logic [7:0]       second_port_lines_out,
   output logic [7:0]       second_port_lines_oe,
   output logic [7:0]       second_port_lines_rdata,
   // Control pins
   input  wire logic        test_in_a_in,
   output logic             test_in_a_out,
   output logic             test_in_a_oe,
   input  wire logic        test_in_b,
   input  wire logic        irq_n,
   input  wire logic        step_n,
   input  wire logic        force_external_fetch
);
   mxb_state_t  state;                      // Cycle phase
   mxb_state_t  next_state;
   logic [3:0]  strb_cnt;                   // Strobe phase counter
   logic [2:0]  cur_kind;                   // Kind of current cycle
   logic [11:0] cur_addr;                   // Address of current cycle
   logic [7:0]  cur_wdata;                  // Write data of current cycle
   logic        cur_ext;                    // Fetch goes off chip
   logic        cur_last;                   // Last cycle of instruction
   logic        bus_hold;                   // Bus output kept driven
   logic        clk_div;                    // Clock for the test pin
   logic        tb_prev;                    // Last stable test b level
   logic [NSYNC-1:0] s1;                    // Pin sync stages
   logic [NSYNC-1:0] s2;
   logic [NSYNC-1:0] s3;
   logic [NSYNC-1:0] lvl;                   // Stable pin levels

   // ---------------------------------------------------------------
   // Pin input synchronisers
   // ---------------------------------------------------------------
   logic [NSYNC-1:0] raw;
   assign raw = {force_external_fetch, step_n, test_in_b, test_in_a_in, irq_n, bus_in};

   genvar i;
   generate
      for (i = 0; i < NSYNC; i++) begin : g_sync
         // Level counts once stages two and three agree
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               s1[i]  <= 1'b1;
               s2[i]  <= 1'b1;
               s3[i]  <= 1'b1;
               lvl[i] <= 1'b1;
            end else begin
               s1[i] <= raw[i];
               s2[i] <= s1[i];
               s3[i] <= s2[i];
               if (s2[i] == s3[i]) begin
                  lvl[i] <= s3[i];
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Cycle decode
   // ---------------------------------------------------------------
   logic is_efetch;                         // External program fetch
   logic is_drd;
   logic is_dwr;
   logic is_bin;
   logic is_bout;
   logic is_exp;
   logic addr_ph;                           // Address on the bus
   logic strb_ph;                           // Strobe window
   logic take;                              // Request taken
   logic take_ext;                          // Taken fetch is external
   logic push;                              // Word captured for core
   logic [7:0] push_data;
   logic buf_in_ready;
   logic room;                              // Buffer can take one more

   assign is_efetch = (cur_kind == K_FETCH) && cur_ext;
   assign is_drd    = (cur_kind == K_DRD);
   assign is_dwr    = (cur_kind == K_DWR);
   assign is_bin    = (cur_kind == K_BIN);
   assign is_bout   = (cur_kind == K_BOUT);
   assign is_exp    = (cur_kind == K_XRD) || (cur_kind == K_XWR);
   assign addr_ph   = (state == ST_ADDR) || (state == ST_HOLD);
   assign strb_ph   = (state == ST_STRB) || (state == ST_CAPT);
   assign take      = (state == ST_END) && req_valid && req_ready;
   assign take_ext  = lvl[S_FRC] || (req_addr >= INT_ROM_TOP);
   assign push      = (state == ST_CAPT) && (is_efetch || is_drd || is_bin || cur_kind == K_XRD);
   assign push_data = (cur_kind == K_XRD) ? {NIB_OFF, second_port_lines_rdata[3:0]} : lvl[7:0];
   assign room      = buf_in_ready && !(push && rd_valid);

   // ---------------------------------------------------------------
   // Phase sequencing
   // ---------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ST_ADDR: next_state = ST_HOLD;
         ST_HOLD: next_state = ST_STRB;
         ST_STRB: next_state = (strb_cnt == STRB_LAST) ? ST_CAPT : ST_STRB;
         ST_CAPT: next_state = ST_END;
         ST_END:  next_state = (cur_last && !lvl[S_STP]) ? ST_HALT : ST_ADDR;
         ST_HALT: next_state = lvl[S_STP] ? ST_END : ST_HALT;
         default: next_state = ST_ADDR;
      endcase
   end

   // Phase and strobe counter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state    <= ST_END;
         strb_cnt <= 4'h0;
      end else begin
         state    <= next_state;
         strb_cnt <= (state == ST_STRB) ? strb_cnt + 4'h1 : 4'h0;
      end
   end

   // Current cycle, loaded in every ST_END phase; K_IDLE when no request is taken
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cur_kind  <= K_IDLE;
         cur_addr  <= 12'h000;
         cur_wdata <= 8'h00;
         cur_ext   <= 1'b0;
         cur_last  <= 1'b0;
      end else if (state == ST_END) begin
         cur_kind  <= take ? req_kind : K_IDLE;
         cur_addr  <= req_addr;
         cur_wdata <= req_wdata;
         cur_ext   <= take_ext;
         cur_last  <= take && req_last;
      end
   end

   // ---------------------------------------------------------------
   // Bus and strobe outputs
   // ---------------------------------------------------------------
   logic       addr_drv;
   logic       data_drv;
   logic       next_bus_oe;
   logic [7:0] next_bus_out;

   assign addr_drv     = addr_ph && (is_efetch || is_drd || is_dwr);
   assign data_drv     = !addr_ph && (state != ST_HALT) && (is_dwr || is_bout);
   assign next_bus_oe  = addr_drv || data_drv || (bus_hold && !strb_ph && !addr_ph);
   assign next_bus_out = addr_drv ? cur_addr[7:0] : (data_drv ? cur_wdata : bus_out);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_out        <= 8'h00;
         bus_oe         <= 1'b0;
         bus_hold       <= 1'b0;
         addr_strobe    <= 1'b0;
         fetch_strobe_n <= 1'b1;
         read_strobe_n  <= 1'b1;
         write_strobe_n <= 1'b1;
         exp_strobe_n   <= 1'b1;
         halted         <= 1'b0;
         req_ready      <= 1'b0;
      end else begin
         bus_out        <= next_bus_out;
         bus_oe         <= next_bus_oe;
         bus_hold       <= is_bout || (bus_hold && !addr_drv && !strb_ph);
         // at most one strobe per cycle; none for idle and internal fetch cycles
         // Registered from ST_ADDR, so it rises on the same edge as the address and falls one phase before the bus is released
         addr_strobe    <= (state == ST_ADDR) || (state == ST_HALT);
         fetch_strobe_n <= !(strb_ph && is_efetch);
         read_strobe_n  <= !(strb_ph && (is_drd || is_bin));
         write_strobe_n <= !(strb_ph && (is_dwr || is_bout));
         exp_strobe_n   <= !(strb_ph && is_exp);
         halted         <= (next_state == ST_HALT);
         req_ready      <= (next_state == ST_END) && room;
      end
   end

   // ---------------------------------------------------------------
   // Second port overrides
   // ---------------------------------------------------------------
   logic [3:0] p2_en;
   logic [3:0] p2_oe;
   logic [3:0] p2_val;
   logic       xw_data;

   assign xw_data = strb_ph && (cur_kind == K_XWR);
   assign p2_en   = (is_efetch || is_exp) ? NIB_ON : NIB_OFF;
   assign p2_oe   = (is_efetch || (is_exp && addr_ph) || xw_data) ? NIB_ON : NIB_OFF;
   assign p2_val  = is_efetch ? cur_addr[11:8] : (xw_data ? cur_wdata[3:0] : cur_addr[3:0]);

   mxb_qport u_port1 (
      .clk     (clk),
      .nrst    (nrst),
      .wr      (p1_wr),
      .wdata   (p1_wdata),
      .ovr_en  (8'h00),
      .ovr_oe  (8'h00),
      .ovr_val (8'h00),
      .pin_in  (first_port_lines_in),
      .pin_out (first_port_lines_out),
      .pin_oe  (first_port_lines_oe),
      .rdata   (first_port_lines_rdata)
   );

   mxb_qport u_port2 (
      .clk     (clk),
      .nrst    (nrst),
      .wr      (p2_wr),
      .wdata   (p2_wdata),
      .ovr_en  ({NIB_OFF, p2_en}),
      .ovr_oe  ({NIB_OFF, p2_oe}),
      .ovr_val ({NIB_OFF, p2_val}),
      .pin_in  (second_port_lines_in),
      .pin_out (second_port_lines_out),
      .pin_oe  (second_port_lines_oe),
      .rdata   (second_port_lines_rdata)
   );

   // Captured words toward the core
   mxb_buf2 u_buf (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (push),
      .in_ready  (buf_in_ready),
      .in_data   (push_data),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );

   // ---------------------------------------------------------------
   // Test, interrupt and reset pins
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         test_a_level  <= 1'b1;
         test_b_level  <= 1'b1;
         irq_level     <= 1'b1;
         irq_request   <= 1'b0;
         count_event   <= 1'b0;
         tb_prev       <= 1'b1;
         clk_div       <= 1'b0;
         test_in_a_out <= 1'b0;
         test_in_a_oe  <= 1'b0;
         core_reset_n  <= 1'b0;
      end else begin
         test_a_level  <= lvl[S_TA];
         test_b_level  <= lvl[S_TB];
         irq_level     <= lvl[S_IRQ];
         irq_request   <= !lvl[S_IRQ];
         count_event   <= event_count_start && tb_prev && !lvl[S_TB];
         tb_prev       <= lvl[S_TB];
         clk_div       <= !clk_div;
         test_in_a_out <= clk_div;
         test_in_a_oe  <= clock_out_enable;
         core_reset_n  <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   localparam int GAP_MAX = CYCLE_CLKS - 1;
   int gap;                                 // Clocks since address strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gap <= 0;
      end else begin
         gap <= addr_strobe ? 0 : gap + 1;
      end
   end

   property p_ale_every; (gap <= GAP_MAX) and (addr_strobe && !halted |=> !addr_strobe); endproperty
   a_ale_every: assert property (p_ale_every) else $error("address strobe missing or long");
   property p_fetch_addr; $rose(addr_strobe) && is_efetch |-> bus_oe && bus_out == cur_addr[7:0]; endproperty
   a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address not on bus");
   property p_upper; $rose(addr_strobe) && is_efetch |-> second_port_lines_out[3:0] == cur_addr[11:8]; endproperty
   a_upper: assert property (p_upper) else $error("upper address not on port");
   property p_drd; $rose(addr_strobe) && is_drd |-> bus_oe ##[1:3] !read_strobe_n; endproperty
   a_drd: assert property (p_drd) else $error("data read sequence wrong");
   property p_hold; !write_strobe_n && $past(!write_strobe_n) |-> bus_oe && $stable(bus_out); endproperty
   a_hold: assert property (p_hold) else $error("write data moved");
   property p_rd; !read_strobe_n |-> is_drd || is_bin; endproperty
   a_rd: assert property (p_rd) else $error("read strobe in wrong cycle");
   property p_wr; !write_strobe_n |-> is_dwr || is_bout; endproperty
   a_wr: assert property (p_wr) else $error("write strobe in wrong cycle");
   property p_psen; !fetch_strobe_n |-> is_efetch; endproperty
   a_psen: assert property (p_psen) else $error("fetch strobe without external fetch");
   property p_force; take && req_kind == K_FETCH && lvl[S_FRC] |=> cur_ext; endproperty
   a_force: assert property (p_force) else $error("forced fetch stayed internal");

   c_fetch: cover property ($rose(addr_strobe) && is_efetch ##[1:12] rd_valid);
   c_write: cover property (!write_strobe_n && is_dwr);
   c_halt:  cover property ($rose(halted) ##[1:40] !halted);
endmodule

// >>> src/mxb_pkg.sv
// mxb_pkg: shared constants for the external bus and port pin block.
// Assumes one 20 MHz clock; no registers reachable by software.
// Function
// - One address strobe pulse every machine cycle
// - External fetch drives low program address with strobe
// - Memory returns code during fetch strobe
// - External fetch puts upper address on port
// - Data address first, then read/write strobe
// - Written bus data held stable while driven
// - Read strobe on data reads, bus input
// - Write strobe on data writes, bus output
// - Fetch strobe only for external program fetch
// - Force input makes every fetch external
// - Both general ports are quasi-bidirectional
// - Port low nibble is expander bus, strobed
// - Test and interrupt levels feed jumps
// - Clock out enable drives clock on test pin
// - Test pin b falling edges become count events
// - Single step halts after each instruction
// - Interrupt input requests processor interrupt
// - Reset input initializes processor state
package mxb_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_NS     = 50;                          // Clock period
   localparam int STROBE_NS  = 300;                         // Least strobe width
   localparam int STRB_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYCLE_CLKS = STRB_CYC + 4;                // Clocks per machine cycle
   localparam logic [3:0] STRB_LAST = 4'(STRB_CYC - 1);     // Strobe counter end

   // ---------------------------------------------------------------
   // Address map and reset values
   // ---------------------------------------------------------------
   localparam logic [11:0] INT_ROM_TOP = 12'h800;           // 2048 bytes internal
   localparam logic [7:0]  PORT_RESET  = 8'hff;             // Port latch after reset
   localparam logic [3:0]  NIB_ON      = 4'hf;
   localparam logic [3:0]  NIB_OFF     = 4'h0;

   // ---------------------------------------------------------------
   // Cycle kinds requested by the core
   // ---------------------------------------------------------------
   localparam logic [2:0] K_IDLE  = 3'h0;                   // Internal cycle
   localparam logic [2:0] K_FETCH = 3'h1;                   // Program fetch
   localparam logic [2:0] K_DRD   = 3'h2;                   // External data read
   localparam logic [2:0] K_DWR   = 3'h3;                   // External data write
   localparam logic [2:0] K_BIN   = 3'h4;                   // Bus input
   localparam logic [2:0] K_BOUT  = 3'h5;                   // Bus output
   localparam logic [2:0] K_XRD   = 3'h6;                   // Expander read
   localparam logic [2:0] K_XWR   = 3'h7;                   // Expander write

   // Synchroniser slots for pin inputs
   localparam int NSYNC = 13;
   localparam int S_IRQ = 8;
   localparam int S_TA  = 9;
   localparam int S_TB  = 10;
   localparam int S_STP = 11;
   localparam int S_FRC = 12;

   // Machine cycle phases
   typedef enum logic [2:0] {ST_ADDR, ST_HOLD, ST_STRB, ST_CAPT, ST_END, ST_HALT} mxb_state_t;

endpackage

// >>> src/mxb_buf2.sv
// mxb_buf2: two-entry buffer between captured bus words and the core.
// Assumes both sides on clk; all outputs come from flip-flops.
`timescale 1ns/1ps
module mxb_buf2
   import mxb_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       in_valid,
   output logic            in_ready,
   input  wire logic [7:0] in_data,
   output logic            out_valid,
   input  wire logic       out_ready,
   output logic [7:0]      out_data
);
   logic       spare_v;                     // Second entry full
   logic [7:0] spare;                       // Second entry data
   logic       next_spare_v;
   logic       push;
   logic       pop;
   logic       head_free;

   // ---------------------------------------------------------------
   // Handshake decode
   // ---------------------------------------------------------------
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign head_free = !out_valid || pop;

   // Spare fills when head cannot take the word, drains into head
   always_comb begin
      next_spare_v = spare_v;
      if (head_free) begin
         next_spare_v = spare_v && push;
      end else if (push) begin
         next_spare_v = 1'b1;
      end
   end

   // Head and spare storage
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         out_valid <= 1'b0;
         out_data  <= 8'h00;
         spare     <= 8'h00;
         spare_v   <= 1'b0;
         in_ready  <= 1'b1;
      end else begin
         spare_v  <= next_spare_v;
         in_ready <= !next_spare_v;
         if (head_free) begin
            out_valid <= spare_v || push;
            out_data  <= spare_v ? spare : in_data;
         end
         if (push && (spare_v || !head_free)) begin
            spare <= in_data;
         end
      end
   end
endmodule

// >>> src/mxb_qport.sv
// mxb_qport: one 8-bit quasi-bidirectional port with override lanes.
// Assumes pins are asynchronous; the core writes the latch on clk.
`timescale 1ns/1ps
module mxb_qport
   import mxb_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       wr,
   input  wire logic [7:0] wdata,
   input  wire logic [7:0] ovr_en,
   input  wire logic [7:0] ovr_oe,
   input  wire logic [7:0] ovr_val,
   input  wire logic [7:0] pin_in,
   output logic [7:0]      pin_out,
   output logic [7:0]      pin_oe,
   output logic [7:0]      rdata
);
   logic [7:0] latch;                       // Port output latch
   logic [7:0] s1;                          // Sync stages
   logic [7:0] s2;
   logic [7:0] s3;

   // Output latch, all ones after reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         latch <= PORT_RESET;
      end else if (wr) begin
         latch <= wdata;
      end
   end

   // ---------------------------------------------------------------
   // Per-pin drive and input sampling
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_pin
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               pin_out[i] <= 1'b0;
               pin_oe[i]  <= 1'b0;
               s1[i]      <= 1'b1;
               s2[i]      <= 1'b1;
               s3[i]      <= 1'b1;
               rdata[i]   <= 1'b1;
            end else begin
               pin_out[i] <= ovr_en[i] && ovr_val[i];
               pin_oe[i]  <= ovr_en[i] ? ovr_oe[i] : !latch[i];
               s1[i]      <= pin_in[i];
               s2[i]      <= s1[i];
               s3[i]      <= s2[i];
               if (s2[i] == s3[i]) begin
                  rdata[i] <= s3[i];
               end
            end
         end
      end
   endgenerate
endmodule

// >>> sim/mxb_mem_model.sv
// Partner model: external memory, address latch and write catcher.
// Assumes the strobes of mxb_pins; the bench picks each read value.
`timescale 1ns/1ps
module mxb_mem_model
   import mxb_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       addr_strobe,
   input  wire logic [7:0] bus_out,
   input  wire logic [3:0] addr_hi,
   input  wire logic       fetch_strobe_n,
   input  wire logic       read_strobe_n,
   input  wire logic       write_strobe_n,
   input  wire logic [7:0] rd_val,
   output logic [7:0]      bus_in,
   output logic [11:0]     lat_addr,
   output logic [7:0]      wr_seen
);
   initial bus_in = 8'h00;
   always @(negedge addr_strobe) lat_addr = {addr_hi, bus_out};
   // answer while strobed; a released bus toggles
   always @(posedge clk) bus_in <= (!fetch_strobe_n || !read_strobe_n) ? rd_val : ~bus_in;
   // last value seen under write strobe
   always @(posedge clk) if (!write_strobe_n) wr_seen <= bus_out;
endmodule

// >>> sim/mxb_pins_bench.sv
// Bench for mxb_pins: random cycles against a queue model.
// Assumes mxb_mem_model on the bus; clock 50 ns.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module mxb_pins_bench;
   import mxb_pkg::*;
   logic clk, nrst, req_valid, req_ready, req_last, rd_valid, rd_ready, p1_wr, p2_wr, clock_out_enable;
   logic event_count_start, test_a_level, test_b_level, irq_level, irq_request, count_event, core_reset_n;
   logic halted, bus_oe, addr_strobe, fetch_strobe_n, read_strobe_n, write_strobe_n, exp_strobe_n;
   logic test_in_a_in, test_in_a_out, test_in_a_oe, test_in_b, irq_n, step_n, force_external_fetch;
   logic [2:0] req_kind;
   logic [11:0] req_addr, lat_addr;
   logic [7:0] req_wdata, rd_data, p1_wdata, p2_wdata, bus_in, bus_out, rd_val, wr_seen;
   logic [7:0] first_port_lines_in, first_port_lines_out, first_port_lines_oe, first_port_lines_rdata;
   logic [7:0] second_port_lines_in, second_port_lines_out, second_port_lines_oe, second_port_lines_rdata;
   int miscompares = 0, n_checks = 0, as_cnt, cnt[4];
   int smap[8] = '{4, 0, 1, 2, 1, 2, 3, 3};   // Strobe used by each cycle kind
   logic [7:0] q[$];                          // Expected read words
   mxb_pins u_dut (.*);
   mxb_mem_model u_mem (.clk(clk), .addr_strobe(addr_strobe), .bus_out(bus_out),
      .addr_hi(second_port_lines_out[3:0]), .fetch_strobe_n(fetch_strobe_n), .read_strobe_n(read_strobe_n),
      .write_strobe_n(write_strobe_n), .rd_val(rd_val), .bus_in(bus_in), .lat_addr(lat_addr), .wr_seen(wr_seen));
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   // Strobe low counts and a stalling receiver
   always @(posedge clk) begin
      cnt[0] += !fetch_strobe_n; cnt[1] += !read_strobe_n; cnt[2] += !write_strobe_n; cnt[3] += !exp_strobe_n;
      rd_ready <= 1'($urandom);
   end
   always @(posedge addr_strobe) as_cnt++;
   always @(posedge clk) if (rd_valid === 1'b1 && rd_ready === 1'b1) `CHK(rd_data, q.pop_front())
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One random machine cycle request and its pin checks
   task automatic run(input int t);
      logic [2:0] k; logic [11:0] a; logic [7:0] d; int s, n;
      k = 3'($urandom); a = 12'($urandom); d = 8'($urandom); s = smap[k]; n = 0;
      force_external_fetch <= 1'($urandom); irq_n <= 1'($urandom); test_in_b <= 1'($urandom);
      second_port_lines_in <= 8'($urandom); rd_val <= 8'($urandom); test_in_a_in <= 1'($urandom);
      event_count_start <= 1'($urandom); first_port_lines_in <= 8'($urandom);
      clock_out_enable <= 1'($urandom);
      repeat (6) @(posedge clk);
      `CHK(irq_request, !irq_n)
      `CHK(test_b_level, test_in_b)
      `CHK(test_a_level, test_in_a_in)
      `CHK(irq_level, irq_n)
      `CHK(first_port_lines_rdata, first_port_lines_in)
      `CHK(first_port_lines_oe, 8'h00)
      `CHK(test_in_a_oe, clock_out_enable)
      `CHK(core_reset_n, 1'b1)
      if (k == K_FETCH && !force_external_fetch && a < INT_ROM_TOP) s = 4;
      if (s < 2) q.push_back(rd_val);
      if (k == K_XRD) q.push_back({4'h0, second_port_lines_in[3:0]});
      req_kind <= k; req_addr <= a; req_wdata <= d; req_valid <= 1'b1;
      do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 60);
      req_valid <= 1'b0;
      if (n >= 60) miscompares++;
      #1 cnt = '{default: 0};
      repeat (10) @(posedge clk);
      #1;
      for (int i = 0; i < 4; i++) `CHK(cnt[i], (i == s) ? 7 : 0)
      if (s < 3 && k inside {K_FETCH, K_DRD, K_DWR}) `CHK(lat_addr[7:0], a[7:0])
      if (s == 0) `CHK(lat_addr[11:8], a[11:8])
      if (s == 2) `CHK(wr_seen, d)
      $display("test %0d kind %0d done", t, k);
      @(posedge clk);
   endtask
   initial begin
      {nrst, req_valid, req_last, rd_ready, p1_wr, p2_wr, clock_out_enable, event_count_start} = '0;
      {req_kind, req_addr, req_wdata, p1_wdata, p2_wdata, rd_val} = '0;
      // step input held high, so the core runs free
      {test_in_a_in, test_in_b, irq_n, step_n, force_external_fetch} = 5'h1f;
      first_port_lines_in = 8'hff; second_port_lines_in = 8'hff;
      void'($urandom(83));
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      for (int t = 0; t < 40; t++) run(t);
      repeat (20) @(posedge clk);
      #1 as_cnt = 0;
      repeat (100) @(posedge clk);
      #1 `CHK(as_cnt, 10)
      `CHK(q.size(), 0)
      final_report();
   end
   initial begin
      #(5000 * 50);
      miscompares++;
      final_report();
   end
endmodule
